// File: verilog/rlc_pkg.sv
// constants, types and helpers for the lane 0 repeater configuration block
package rlc_pkg;

    // ==========================================
    // register map
    localparam logic [7:0] RLC_ADDR_IDLE_TERM = 8'h0E;
    localparam logic [7:0] RLC_ADDR_EQ        = 8'h0F;
    localparam logic [7:0] RLC_ADDR_SWING     = 8'h10;

    localparam logic [7:0] RLC_RST_IDLE_TERM  = 8'h00;
    localparam logic [7:0] RLC_RST_EQ         = 8'h2F;
    localparam logic [7:0] RLC_RST_SWING      = 8'hAD;
    localparam logic [7:0] RLC_RDATA_NONE     = 8'h00;

    // ==========================================
    // field positions
    localparam int RLC_IDLE_AUTO_BIT = 5;
    localparam int RLC_IDLE_SEL_BIT  = 4;
    localparam int RLC_DET_LSB       = 2;
    localparam int RLC_SCP_BIT       = 7;
    localparam int RLC_MODE_BIT      = 6;
    localparam int RLC_SWING_LSB     = 0;

    // ==========================================
    // receiver detect field encodings
    typedef enum logic [1:0] {
        RLC_DET_HIZ       = 2'h0,
        RLC_DET_LIMITED   = 2'h1,
        RLC_DET_UNLIMITED = 2'h2,
        RLC_DET_FIXED_50  = 2'h3
    } rlc_det_type;

    // ==========================================
    // timing
    localparam int RLC_CLOCK_HZ          = 10_000_000;
    localparam int RLC_RETRY_INTERVAL_MS = 12;
    localparam int RLC_RETRY_CYCLES      = RLC_CLOCK_HZ / 1000 * RLC_RETRY_INTERVAL_MS;
    localparam int RLC_TICK_W            = 17;
    localparam logic [5:0] RLC_RETRY_LIMIT = 6'd50;

    // ==========================================
    // output swing decode
    localparam logic [10:0] RLC_SWING_BASE_MV = 11'd700;
    localparam logic [10:0] RLC_SWING_STEP_MV = 11'd100;

    // ==========================================
    // carriers
    typedef struct packed {
        logic [7:0] idle_term;
        logic [7:0] eq;
        logic [7:0] swing;
    } rlc_cfg_type;

    typedef struct packed {
        logic        mute;
        logic        gen12_mode;
        logic        short_protect;
        logic [2:0]  swing_code;
        logic [10:0] swing_mv;
        logic [7:0]  eq_level;
    } rlc_lane_out_type;

    // millivolts for a swing code
    function automatic logic [10:0] rlc_swing_mv(input logic [2:0] code);
        rlc_swing_mv = RLC_SWING_BASE_MV + RLC_SWING_STEP_MV * {8'h00, code};
    endfunction

endpackage

// File: verilog/rlc_detect_seq.sv
// receiver detect sequencer: termination and retry probing for one lane
`timescale 1ns/1ps
module rlc_detect_seq
    import rlc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        tick,
    input  wire rlc_det_type det_mode,
    input  wire logic        probe_hit,
    output logic             probe_pulse,
    output logic             term_50,
    output logic             detected
);

    typedef enum logic [2:0] {
        RLC_SEQ_HIZ,
        RLC_SEQ_PROBE,
        RLC_SEQ_FOUND,
        RLC_SEQ_STOPPED,
        RLC_SEQ_FIXED
    } rlc_seq_type;

    typedef struct packed {
        rlc_seq_type st;
        rlc_det_type mode;
        logic [5:0]  attempts;
        logic        probe;
        logic        term;
    } rlc_seq_state_type;

    rlc_seq_state_type q;
    rlc_seq_state_type d;

    // next state of the sequence
    always_comb begin
        d = q;
        d.probe = 1'b0;
        if (det_mode != q.mode) begin
            // a new field value restarts the whole sequence
            d.mode     = det_mode;
            d.attempts = 6'd0;
            unique case (det_mode)
                RLC_DET_HIZ:      d.st = RLC_SEQ_HIZ;
                RLC_DET_FIXED_50: d.st = RLC_SEQ_FIXED;
                default:          d.st = RLC_SEQ_PROBE;
            endcase
        end else begin
            unique case (q.st)
                RLC_SEQ_PROBE: begin
                    if (probe_hit) begin
                        d.st = RLC_SEQ_FOUND;
                    end else if (tick) begin
                        if (q.mode == RLC_DET_LIMITED && q.attempts == RLC_RETRY_LIMIT) begin
                            d.st = RLC_SEQ_STOPPED;
                        end else begin
                            d.probe = 1'b1;
                            if (q.attempts != RLC_RETRY_LIMIT) begin
                                d.attempts = q.attempts + 6'd1;
                            end
                        end
                    end
                end
                RLC_SEQ_HIZ, RLC_SEQ_FOUND, RLC_SEQ_STOPPED, RLC_SEQ_FIXED: begin
                    d.st = q.st;
                end
            endcase
        end
        // termination is high impedance until detection or fixed mode
        d.term = (d.st == RLC_SEQ_FOUND) || (d.st == RLC_SEQ_FIXED);
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: RLC_SEQ_HIZ, mode: RLC_DET_HIZ, attempts: 6'd0, probe: 1'b0, term: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign probe_pulse = q.probe;
    assign term_50     = q.term;
    assign detected    = (q.st == RLC_SEQ_FOUND);

endmodule

// File: verilog/rlc_lane0_regs.sv
// lane 0 configuration registers of an eight-lane serial repeater
// ==========================================
// Overview of operation
// - With idle-auto set the mute state comes from idle-select, otherwise from input signal detection.
// - Under register idle control, idle-select 1 mutes the output and 0 keeps it active.
// - Detect field 00 holds the input termination at high impedance with no probing.
// - Detect field 01 probes every 12 ms for 50 tries (600 ms), then stops; 50 ohm once detected.
// - Detect field 10 probes every 12 ms without limit; 50 ohm once detected.
// - Detect field 11 presents a fixed 50 ohm termination without probing.
// - Under register detect control, the register field wins over the detect pin.
// - An 8-bit equalizer level with 256 settings resets to 0x2F.
// - Swing register bit 7 enables short-circuit protection; the register resets to 0xAD.
// - Bit 6 of the swing register selects Gen-1/2 (1) or Gen-3 (0) and overrides the mode pin while the global mode override is set.
// - The swing code maps to 0.7 V at 000 up to 1.4 V at 111 in 0.1 V steps; 101 gives 1.2 V.
// - Per-lane idle control applies only while the global idle override is set.
// - Per-lane detect control applies only while the global detect override is set.
`timescale 1ns/1ps
module rlc_lane0_regs
    import rlc_pkg::*;
#(
    parameter int RETRY_CYCLES = RLC_RETRY_CYCLES
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd_en,
    output logic [7:0]       reg_rdata,
    // global override bits
    input  wire logic        global_idle_register_control,
    input  wire logic        global_detect_register_control,
    input  wire logic        global_mode_register_control,
    // pins and analog status, asynchronous
    input  wire logic        signal_detect_async,
    input  wire logic [1:0]  detect_pin_mode_async,
    input  wire logic        mode_pin_gen12_async,
    input  wire logic        far_end_hit_async,
    // lane controls
    output logic             lane0_output_mute,
    output logic             lane0_input_term_50,
    output logic             lane0_probe_pulse,
    output logic             lane0_receiver_detected,
    output logic             lane0_gen12_mode,
    output logic             lane0_short_protect,
    output logic [2:0]       lane0_output_swing_level,
    output logic [10:0]      lane0_output_swing_mv,
    output logic [7:0]       lane0_equalizer_level
);

    // ==========================================
    // state

    typedef struct packed {
        logic [1:0] first;
        logic [1:0] second;
    } rlc_sync2_type;

    typedef struct packed {
        rlc_cfg_type             cfg;
        logic [7:0]              rdata;
        logic                    sd_s1;
        logic                    sd_s2;
        logic                    hit_s1;
        logic                    hit_s2;
        logic                    mode_s1;
        logic                    mode_s2;
        rlc_sync2_type           det_pin;
        logic [1:0]              det_pin_prev;
        logic [RLC_TICK_W-1:0]   tick_cnt;
        logic                    tick;
        rlc_det_type             det_mode;
        rlc_lane_out_type        lane;
    } rlc_top_state_type;

    // swing code field of the swing register, decoded in several places
    function automatic logic [2:0] rlc_swing_code(input logic [7:0] r);
        rlc_swing_code = r[RLC_SWING_LSB +: 3];
    endfunction

    localparam logic [RLC_TICK_W-1:0] TICK_LAST = RLC_TICK_W'(RETRY_CYCLES - 1);

    localparam rlc_top_state_type RESET_STATE = '{
        cfg:      '{idle_term: RLC_RST_IDLE_TERM, eq: RLC_RST_EQ, swing: RLC_RST_SWING},
        rdata:    RLC_RDATA_NONE,
        sd_s1:    1'b0,
        sd_s2:    1'b0,
        hit_s1:   1'b0,
        hit_s2:   1'b0,
        mode_s1:  1'b0,
        mode_s2:  1'b0,
        det_pin:  '{first: 2'h0, second: 2'h0},
        det_pin_prev: 2'h0,
        tick_cnt: '0,
        tick:     1'b0,
        det_mode: RLC_DET_HIZ,
        lane:     '{mute: 1'b0, gen12_mode: RLC_RST_SWING[RLC_MODE_BIT],
                    short_protect: RLC_RST_SWING[RLC_SCP_BIT],
                    swing_code: rlc_swing_code(RLC_RST_SWING),
                    swing_mv: rlc_swing_mv(rlc_swing_code(RLC_RST_SWING)),
                    eq_level: RLC_RST_EQ}
    };

    rlc_top_state_type q;
    rlc_top_state_type d;

    logic              seq_probe;
    logic              seq_term;
    logic              seq_detected;

    // ==========================================
    // next state

    always_comb begin
        d = q;

        // two-stage synchronisers for everything from outside the clock
        d.sd_s1          = signal_detect_async;
        d.sd_s2          = q.sd_s1;
        d.hit_s1         = far_end_hit_async;
        d.hit_s2         = q.hit_s1;
        d.mode_s1        = mode_pin_gen12_async;
        d.mode_s2        = q.mode_s1;
        d.det_pin.first  = detect_pin_mode_async;
        d.det_pin.second = q.det_pin.first;
        d.det_pin_prev   = q.det_pin.second;

        // register writes; reserved bits are stored as written
        if (reg_wr_en) begin
            unique case (reg_addr)
                RLC_ADDR_IDLE_TERM: d.cfg.idle_term = reg_wdata;
                RLC_ADDR_EQ:        d.cfg.eq        = reg_wdata;
                RLC_ADDR_SWING:     d.cfg.swing     = reg_wdata;
                default:            d.cfg           = q.cfg;     // unmapped writes ignored
            endcase
        end

        // register reads, unmapped offsets read zero
        if (reg_rd_en) begin
            unique case (reg_addr)
                RLC_ADDR_IDLE_TERM: d.rdata = q.cfg.idle_term;
                RLC_ADDR_EQ:        d.rdata = q.cfg.eq;
                RLC_ADDR_SWING:     d.rdata = q.cfg.swing;
                default:            d.rdata = RLC_RDATA_NONE;
            endcase
        end

        // free-running retry interval timer
        if (q.tick_cnt == TICK_LAST) begin
            d.tick_cnt = '0;
            d.tick     = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 1'b1;
            d.tick     = 1'b0;
        end

        // detect mode source: register field or detect pin; the pin code is taken only
        // once two samples agree, so skew between its two bits cannot pass a false code
        if (global_detect_register_control) begin
            d.det_mode = rlc_det_type'(q.cfg.idle_term[RLC_DET_LSB +: 2]);
        end else if (q.det_pin.second == q.det_pin_prev) begin
            d.det_mode = rlc_det_type'(q.det_pin.second);
        end

        // output idle: register select only when both controls allow it
        if (global_idle_register_control && q.cfg.idle_term[RLC_IDLE_AUTO_BIT]) begin
            d.lane.mute = q.cfg.idle_term[RLC_IDLE_SEL_BIT];
        end else begin
            d.lane.mute = !q.sd_s2;
        end

        // rate mode: register bit or mode pin
        if (global_mode_register_control) begin
            d.lane.gen12_mode = q.cfg.swing[RLC_MODE_BIT];
        end else begin
            d.lane.gen12_mode = q.mode_s2;
        end

        // swing, protection and equalizer settings
        d.lane.short_protect = q.cfg.swing[RLC_SCP_BIT];
        d.lane.swing_code    = rlc_swing_code(q.cfg.swing);
        d.lane.swing_mv      = rlc_swing_mv(rlc_swing_code(q.cfg.swing));
        d.lane.eq_level      = q.cfg.eq;
    end

    // ==========================================
    // state register

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // receiver detect sequencer

    rlc_detect_seq u_detect_seq (
        .clock       (clock),
        .rst_n       (rst_n),
        .tick        (q.tick),
        .det_mode    (q.det_mode),
        .probe_hit   (q.hit_s2),
        .probe_pulse (seq_probe),
        .term_50     (seq_term),
        .detected    (seq_detected)
    );

    // ==========================================
    // outputs

    assign reg_rdata                = q.rdata;
    assign lane0_output_mute        = q.lane.mute;
    assign lane0_input_term_50      = seq_term;
    assign lane0_probe_pulse        = seq_probe;
    assign lane0_receiver_detected  = seq_detected;
    assign lane0_gen12_mode         = q.lane.gen12_mode;
    assign lane0_short_protect      = q.lane.short_protect;
    assign lane0_output_swing_level = q.lane.swing_code;
    assign lane0_output_swing_mv    = q.lane.swing_mv;
    assign lane0_equalizer_level    = q.lane.eq_level;

endmodule

// File: verification/rlc_lane0_regs_asserts.sv
// assertion checker for the lane 0 configuration registers
`timescale 1ns/1ps
module rlc_lane0_regs_asserts
    import rlc_pkg::*;
#(
    parameter int RETRY_CYCLES = RLC_RETRY_CYCLES
)
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr_en,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd_en,
    input wire logic [7:0]  reg_rdata,
    input wire logic        global_idle_register_control,
    input wire logic        global_detect_register_control,
    input wire logic        global_mode_register_control,
    input wire logic        signal_detect_async,
    input wire logic [1:0]  detect_pin_mode_async,
    input wire logic        mode_pin_gen12_async,
    input wire logic        far_end_hit_async,
    input wire logic        lane0_output_mute,
    input wire logic        lane0_input_term_50,
    input wire logic        lane0_probe_pulse,
    input wire logic        lane0_receiver_detected,
    input wire logic        lane0_gen12_mode,
    input wire logic        lane0_short_protect,
    input wire logic [2:0]  lane0_output_swing_level,
    input wire logic [10:0] lane0_output_swing_mv,
    input wire logic [7:0]  lane0_equalizer_level
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    int   gap_q;
    logic seen_q;
    // ==========================================
    // cycles since the last probe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap_q  <= 0;
            seen_q <= 1'b0;
        end else begin
            gap_q  <= lane0_probe_pulse ? 1 : gap_q + 1;
            seen_q <= seen_q | lane0_probe_pulse;
        end
    end
    // ==========================================
    // properties
    sequence s_wr(logic [7:0] a);
        reg_wr_en && reg_addr == a;
    endsequence
    sequence s_pin(logic [1:0] p);
        (!global_detect_register_control && detect_pin_mode_async == p) [*6];
    endsequence
    AST_EQ_FOLLOW: assert property (s_wr(RLC_ADDR_EQ) |-> ##2 lane0_equalizer_level == $past(reg_wdata, 2))
        else $error("equalizer level does not follow its write");
    AST_SCP_FOLLOW: assert property (s_wr(RLC_ADDR_SWING) |-> ##2 lane0_short_protect == $past(reg_wdata[7], 2))
        else $error("short protect does not follow bit 7");
    AST_MODE_FOLLOW: assert property (s_wr(RLC_ADDR_SWING) ##0 global_mode_register_control [*3] |->
        lane0_gen12_mode == $past(reg_wdata[6], 2))
        else $error("mode does not follow bit 6");
    AST_SWING_MV: assert property (lane0_output_swing_mv == 11'd700 + 11'd100 * {8'h00, lane0_output_swing_level})
        else $error("swing millivolts do not match code");
    AST_MUTE_REG: assert property (s_wr(RLC_ADDR_IDLE_TERM) ##0 (global_idle_register_control && reg_wdata[5]) |->
        ##2 lane0_output_mute == $past(reg_wdata[4], 2))
        else $error("mute does not follow idle select");
    AST_MUTE_AUTO: assert property ((!global_idle_register_control && $stable(signal_detect_async)) [*6] |->
        lane0_output_mute == !signal_detect_async)
        else $error("mute does not follow signal detect");
    AST_PIN_HIZ: assert property (s_pin(2'h0) |-> !lane0_input_term_50 && !lane0_probe_pulse)
        else $error("termination not high impedance");
    AST_PIN_FIXED: assert property (s_pin(2'h3) |-> lane0_input_term_50 && !lane0_probe_pulse)
        else $error("termination not fixed 50 ohm");
    AST_PROBE_GAP: assert property (lane0_probe_pulse && seen_q |-> gap_q % RETRY_CYCLES == 0)
        else $error("probe spacing off the retry grid");
    AST_DET_TERM: assert property (lane0_receiver_detected |-> lane0_input_term_50)
        else $error("detected without 50 ohm termination");
endmodule

bind rlc_lane0_regs rlc_lane0_regs_asserts #(
    .RETRY_CYCLES (RETRY_CYCLES)
) u_asserts (
    .clock                          (clock),
    .rst_n                          (rst_n),
    .reg_addr                       (reg_addr),
    .reg_wr_en                      (reg_wr_en),
    .reg_wdata                      (reg_wdata),
    .reg_rd_en                      (reg_rd_en),
    .reg_rdata                      (reg_rdata),
    .global_idle_register_control   (global_idle_register_control),
    .global_detect_register_control (global_detect_register_control),
    .global_mode_register_control   (global_mode_register_control),
    .signal_detect_async            (signal_detect_async),
    .detect_pin_mode_async          (detect_pin_mode_async),
    .mode_pin_gen12_async           (mode_pin_gen12_async),
    .far_end_hit_async              (far_end_hit_async),
    .lane0_output_mute              (lane0_output_mute),
    .lane0_input_term_50            (lane0_input_term_50),
    .lane0_probe_pulse              (lane0_probe_pulse),
    .lane0_receiver_detected        (lane0_receiver_detected),
    .lane0_gen12_mode               (lane0_gen12_mode),
    .lane0_short_protect            (lane0_short_protect),
    .lane0_output_swing_level       (lane0_output_swing_level),
    .lane0_output_swing_mv          (lane0_output_swing_mv),
    .lane0_equalizer_level          (lane0_equalizer_level)
);

// File: verification/rlc_far_end_model.sv
// far-end receiver model answering lane 0 probes
`timescale 1ns/1ps
module rlc_far_end_model (
    input  wire logic clock,
    input  wire logic probe_pulse,
    input  wire logic present,
    input  wire logic slow,
    output logic      far_end_hit_async
);
    int wait_q = -3;
    // answer a probe after one or six cycles, held for three cycles
    always @(posedge clock) begin
        if (probe_pulse && present) begin
            wait_q <= slow ? 6 : 1;
        end else if (wait_q > -3) begin
            wait_q <= wait_q - 1;
        end
    end
    assign far_end_hit_async = present && wait_q <= 0 && wait_q > -3;
endmodule

// File: verification/tb_rlc_lane0_regs.sv
// self-checking bench for the lane 0 configuration registers
`timescale 1ns/1ps
module tb_rlc_lane0_regs;
    import rlc_pkg::*;
    localparam int RC = 20;
    logic clock = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic global_idle_register_control = 1'b0, global_detect_register_control = 1'b0;
    logic global_mode_register_control = 1'b1, signal_detect_async = 1'b0;
    logic [1:0] detect_pin_mode_async = 2'h0;
    logic mode_pin_gen12_async = 1'b0, present = 1'b0, slow = 1'b0, far_end_hit_async;
    logic lane0_output_mute, lane0_input_term_50, lane0_probe_pulse, lane0_receiver_detected;
    logic lane0_gen12_mode, lane0_short_protect;
    logic [2:0] lane0_output_swing_level;
    logic [10:0] lane0_output_swing_mv;
    logic [7:0] lane0_equalizer_level;
    int errors = 0, compares = 0, probes = 0, cycles = 0;
    rlc_lane0_regs #(.RETRY_CYCLES(RC)) uut (
        .clock                          (clock),
        .rst_n                          (rst_n),
        .reg_addr                       (reg_addr),
        .reg_wr_en                      (reg_wr_en),
        .reg_wdata                      (reg_wdata),
        .reg_rd_en                      (reg_rd_en),
        .reg_rdata                      (reg_rdata),
        .global_idle_register_control   (global_idle_register_control),
        .global_detect_register_control (global_detect_register_control),
        .global_mode_register_control   (global_mode_register_control),
        .signal_detect_async            (signal_detect_async),
        .detect_pin_mode_async          (detect_pin_mode_async),
        .mode_pin_gen12_async           (mode_pin_gen12_async),
        .far_end_hit_async              (far_end_hit_async),
        .lane0_output_mute              (lane0_output_mute),
        .lane0_input_term_50            (lane0_input_term_50),
        .lane0_probe_pulse              (lane0_probe_pulse),
        .lane0_receiver_detected        (lane0_receiver_detected),
        .lane0_gen12_mode               (lane0_gen12_mode),
        .lane0_short_protect            (lane0_short_protect),
        .lane0_output_swing_level       (lane0_output_swing_level),
        .lane0_output_swing_mv          (lane0_output_swing_mv),
        .lane0_equalizer_level          (lane0_equalizer_level)
    );
    rlc_far_end_model far_end (.clock(clock), .probe_pulse(lane0_probe_pulse), .present(present),
        .slow(slow), .far_end_hit_async(far_end_hit_async));
    initial begin
        forever #50 clock = ~clock;
    end
    // probe count and run ceiling
    always @(posedge clock) begin
        probes += lane0_probe_pulse;
        cycles++;
        if (cycles == 6000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = v;
        reg_wr_en = 1'b1;
        @(negedge clock);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clock);
        reg_rd_en = 1'b0;
        chk("rdata", {3'h0, exp}, {3'h0, reg_rdata});
    endtask
    task automatic idle_case(input logic gi, input logic [7:0] v, input logic s, input logic m);
        global_idle_register_control = gi;
        signal_detect_async = s;
        wr(RLC_ADDR_IDLE_TERM, v);
        wait_n(6);
        chk("mute", {10'h0, m}, {10'h0, lane0_output_mute});
    endtask
    initial begin
        wait_n(4);
        rst_n = 1'b1;
        rd(RLC_ADDR_IDLE_TERM, 8'h00);
        rd(RLC_ADDR_EQ, 8'h2F);
        rd(RLC_ADDR_SWING, 8'hAD);
        wr(8'h11, 8'hFF);
        rd(8'h11, 8'h00);
        rd(RLC_ADDR_SWING, 8'hAD);
        chk("mv", 11'd1200, lane0_output_swing_mv);
        $display("test reset values done");
        for (int i = 0; i < 2; i++) begin
            d = i ? 8'hFF : 8'h00;
            wr(RLC_ADDR_EQ, d);
            rd(RLC_ADDR_EQ, d);
            chk("eq", {3'h0, d}, {3'h0, lane0_equalizer_level});
        end
        for (int c = 0; c < 8; c++) begin
            d = {c[0], c[1], 3'b101, c[2:0]};
            wr(RLC_ADDR_SWING, d);
            rd(RLC_ADDR_SWING, d);
            chk("swing", 11'(c), {8'h0, lane0_output_swing_level});
            chk("mv", 11'(700 + 100 * c), lane0_output_swing_mv);
            chk("scp", {10'h0, c[0]}, {10'h0, lane0_short_protect});
            chk("gen12", {10'h0, c[1]}, {10'h0, lane0_gen12_mode});
        end
        global_mode_register_control = 1'b0;
        mode_pin_gen12_async = 1'b1;
        wait_n(6);
        chk("gen12_pin", 11'h1, {10'h0, lane0_gen12_mode});
        $display("test equalizer and swing done");
        idle_case(1'b1, 8'h30, 1'b1, 1'b1);
        idle_case(1'b1, 8'h20, 1'b0, 1'b0);
        idle_case(1'b1, 8'h10, 1'b0, 1'b1);
        idle_case(1'b1, 8'h10, 1'b1, 1'b0);
        idle_case(1'b0, 8'h30, 1'b1, 1'b0);
        idle_case(1'b0, 8'h20, 1'b0, 1'b1);
        $display("test idle control done");
        detect_pin_mode_async = 2'h3;
        wait_n(6);
        chk("term_pin", 11'h1, {10'h0, lane0_input_term_50});
        global_detect_register_control = 1'b1;
        for (int f = 0; f < 4; f += 3) begin
            probes = 0;
            wr(RLC_ADDR_IDLE_TERM, 8'(f << 2));
            wait_n(3 * RC);
            chk("probes", 11'h0, 11'(probes));
            chk("term", 11'(f == 3), {10'h0, lane0_input_term_50});
        end
        slow = 1'b1;
        probes = 0;
        wr(RLC_ADDR_IDLE_TERM, 8'h08);
        wait_n(60 * RC);
        chk("many", 11'h1, {10'h0, probes > 50});
        present = 1'b1;
        wait_n(3 * RC);
        chk("detected", 11'h1, {10'h0, lane0_receiver_detected});
        present = 1'b0;
        probes = 0;
        wr(RLC_ADDR_IDLE_TERM, 8'h04);
        wait_n(56 * RC);
        chk("probes", 11'd50, 11'(probes));
        present = 1'b1;
        slow = 1'b0;
        wait_n(3 * RC);
        chk("term", 11'h0, {10'h0, lane0_input_term_50});
        wr(RLC_ADDR_IDLE_TERM, 8'h08);
        wait_n(3 * RC);
        chk("detected", 11'h1, {10'h0, lane0_receiver_detected});
        $display("test receiver detect done");
        rst_n = 1'b0;
        wait_n(2);
        rst_n = 1'b1;
        chk("term_rst", 11'h0, {10'h0, lane0_input_term_50});
        chk("det_rst", 11'h0, {10'h0, lane0_receiver_detected});
        chk("mv_rst", 11'd1200, lane0_output_swing_mv);
        rd(RLC_ADDR_EQ, 8'h2F);
        rd(RLC_ADDR_IDLE_TERM, 8'h00);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
